// ### hdl/acm_pkg.sv
// Shared constants, state types and carriers of the converter mode control block
package acm_pkg;

	// Mode field position in the mode control byte and its codes
	localparam int MODE_MSB = 6;
	localparam int MODE_LSB = 4;
	localparam logic [2:0] MODE_CONT = 3'h0;
	localparam logic [2:0] MODE_SINGLE = 3'h1;
	localparam logic [2:0] MODE_STANDBY = 3'h2;
	localparam logic [2:0] MODE_POWERDOWN = 3'h3;
	localparam logic [2:0] MODE_INT_ZERO_CAL = 3'h4;
	localparam logic [2:0] MODE_SYS_ZERO_CAL = 3'h6;
	localparam logic [2:0] MODE_SYS_FULL_CAL = 3'h7;

	// Status byte layout
	localparam int STATUS_READY_BIT = 7;
	localparam int STATUS_CH_MSB = 1;

	// Coefficients and scaling
	localparam logic [23:0] OFFSET_RESET = 24'h800000;
	localparam logic [23:0] GAIN_RESET = 24'h555555;
	localparam logic [23:0] MID_SCALE = 24'h800000;
	localparam logic [23:0] FULL_SCALE = 24'h7FFFFF;
	localparam logic [23:0] CODE_MAX = 24'hFFFFFF;
	localparam int GAIN_SHIFT = 22;
	localparam logic [44:0] DIV_NUMERATOR = {FULL_SCALE[22:0], 22'h000000};
	localparam logic [5:0] DIV_LAST_STEP = 6'h2C;

	// Serial framing
	localparam logic [7:0] CMD_READ_DATA = 8'h44;
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] WORD_BITS = 6'h18;
	localparam logic [5:0] WORD_STAT_BITS = 6'h20;
	localparam logic [5:0] BIT_CNT_MAX = 6'h3F;
	localparam logic [6:0] RESET_ONES = 7'h40;

	// Timing
	localparam int CORE_CLK_MHZ = 100;
	localparam int RESET_WAIT_US = 500;
	localparam int RESET_WAIT_CYCLES = RESET_WAIT_US * CORE_CLK_MHZ;
	localparam int SETTLE_CYCLES_DEFAULT = 1000;

	typedef enum logic [2:0] {ST_CONT, ST_SINGLE, ST_STANDBY, ST_POWERDOWN, ST_CAL, ST_DIV} acm_state_type;
	typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_SKIP, PH_END} acm_phase_type;

	typedef struct packed {
		logic [23:0] result;
		logic [7:0] status;
		logic with_status;
	} acm_word_type;

	typedef struct packed {
		acm_state_type state;
		logic [1:0] channel;
		logic [31:0] cnt;
		logic pending;
		logic [23:0] sample;
		logic [1:0] sample_ch;
		logic ready_n;
		logic [23:0] result;
		logic [1:0] res_ch;
		logic stat_app;
		logic [23:0] offset;
		logic [23:0] gain;
		logic [2:0] cal_code;
		logic cont_active;
		logic flag_d;
		logic flush;
		logic [1:0] rd_sync;
		logic [2:0] done_sync;
		logic [2:0] exit_sync;
		logic [2:0] swr_sync;
		logic [31:0] settle_cnt;
		logic [44:0] div_num;
		logic [25:0] div_rem;
		logic [44:0] div_quo;
		logic [24:0] div_den;
		logic [5:0] div_step;
	} acm_core_type;

	typedef struct packed {
		logic [1:0] cont_sync;
		logic done_tgl;
		logic exit_tgl;
		logic swr_tgl;
		logic [6:0] ones_cnt;
	} acm_link_type;

	typedef struct packed {
		logic [5:0] bit_cnt;
		logic [7:0] cmd;
		acm_phase_type phase;
		logic reading;
	} acm_frame_type;

	localparam acm_core_type CORE_RESET = '{state: ST_CONT, ready_n: 1'b1, offset: OFFSET_RESET,
		gain: GAIN_RESET, default: '0};
	localparam acm_link_type LINK_RESET = '{default: '0};
	localparam acm_frame_type FRAME_RESET = '{phase: PH_CMD, default: '0};

endpackage

// ### hdl/acm_mode_control.sv
// Operating mode, sequencing, calibration and serial read path of the converter
`timescale 1ns/1ps

module acm_mode_control #(
	parameter int SETTLE_CYCLES = acm_pkg::SETTLE_CYCLES_DEFAULT,
	parameter int RESET_WAIT_CYCLES = acm_pkg::RESET_WAIT_CYCLES
) (
	input wire logic core_clk, // Core clock, 100 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [7:0] mode_control, // Mode control byte, mode field in bits 6:4
	input wire logic mode_write, // Pulse: take the mode field
	input wire logic [3:0] channel_enable, // One bit per input channel
	input wire logic data_stat_flag, // Append status byte to each data read
	input wire logic continuous_read_flag, // Request continuous read mode
	input wire logic bipolar_mode, // Bipolar output coding
	input wire logic ref_enable, // Keep the reference up in standby
	input wire logic [1:0] clock_source_select, // Clock source, 00 is the internal oscillator
	input wire logic [23:0] raw_sample, // Modulator result, signed, valid at conversion end
	input wire logic offset_write, // Pulse: load offset coefficient
	input wire logic gain_write, // Pulse: load gain coefficient
	input wire logic [23:0] coef_wdata, // Coefficient write data
	output logic [1:0] conv_channel, // Channel being converted
	output logic [23:0] data_word, // Data register
	output logic [7:0] status_byte, // Status register
	output logic [23:0] offset_value, // Offset coefficient
	output logic [23:0] gain_value, // Gain coefficient
	output logic continuous_read_flag_active, // Continuous read in force
	output logic calibrating, // Calibration in progress
	output logic powered_down, // Power-down state
	output logic ref_power_on, // Internal reference supplied
	output logic osc_power_on, // Crystal oscillator supplied
	output logic gpio_tristate, // General outputs released
	output logic reset_settling, // Serial reset recovery window running
	input wire logic sclk, // Serial clock from the host
	input wire logic cs_n, // Chip select, active low
	input wire logic din, // Serial data in
	output logic dout, // Serial data out and ready
	output logic dout_oe // Output enable of dout
);

	acm_pkg::acm_core_type c_reg, c_next;
	acm_pkg::acm_link_type p_reg, p_next;
	acm_pkg::acm_frame_type f_reg, f_next;
	acm_pkg::acm_word_type word;
	logic read_done, exit_evt, swr_evt;
	logic [2:0] nxt;
	logic [2:0] code;
	logic signed [25:0] cal_diff;
	logic [25:0] rem_sh;
	logic [44:0] quo_n;
	logic frame_rst;
	logic cont;
	logic [5:0] word_len;
	logic [5:0] idx;
	logic show;
	logic [7:0] cmd_full;
	logic [31:0] out_bits;

	// Lowest enabled channel at or above the start index; bit 2 says one was found
	function automatic logic [2:0] next_chan(input logic [3:0] en, input logic [2:0] from);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 3; i >= 0; i--)
		begin
			if (en[i] && (3'(i) >= from))
				r = {1'b1, 2'(i)};
		end
		return r;
	endfunction

	function automatic logic signed [25:0] diff_of(input logic [23:0] raw, input logic [23:0] off);
		diff_of = $signed({{2{raw[23]}}, raw}) - $signed({2'h0, off}) + $signed({2'h0, acm_pkg::MID_SCALE});
	endfunction

	// Offset and gain applied to every stored result
	function automatic logic [23:0] scale(input logic [23:0] raw, input logic [23:0] off,
		input logic [23:0] gain, input logic bip);
		logic signed [50:0] val;
		val = diff_of(raw, off) * $signed({1'b0, gain});
		val = val >>> acm_pkg::GAIN_SHIFT;
		if (bip)
			val = val + $signed({27'h0, acm_pkg::MID_SCALE});
		else
			val = val <<< 1;
		if (val < 51'sh0)
			scale = 24'h000000;
		else if (val > $signed({27'h0, acm_pkg::CODE_MAX}))
			scale = acm_pkg::CODE_MAX;
		else
			scale = val[23:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Core domain

	always_comb
	begin
		c_next = c_reg;
		read_done = c_reg.done_sync[2] ^ c_reg.done_sync[1];
		exit_evt = c_reg.exit_sync[2] ^ c_reg.exit_sync[1];
		swr_evt = c_reg.swr_sync[2] ^ c_reg.swr_sync[1];
		nxt = 3'h0;
		code = mode_control[acm_pkg::MODE_MSB:acm_pkg::MODE_LSB];
		cal_diff = diff_of(raw_sample, c_reg.offset);
		rem_sh = {c_reg.div_rem[24:0], c_reg.div_num[44]};
		quo_n = {c_reg.div_quo[43:0], rem_sh >= {1'b0, c_reg.div_den}};
		c_next.rd_sync = {c_reg.rd_sync[0], f_reg.reading};
		c_next.done_sync = {c_reg.done_sync[1:0], p_reg.done_tgl};
		c_next.exit_sync = {c_reg.exit_sync[1:0], p_reg.exit_tgl};
		c_next.swr_sync = {c_reg.swr_sync[1:0], p_reg.swr_tgl};
		c_next.flag_d = continuous_read_flag;
		c_next.stat_app = data_stat_flag;
		c_next.flush = 1'b0;
		c_next.pending = 1'b0;
		if (c_reg.settle_cnt != 32'h00000000)
			c_next.settle_cnt = c_reg.settle_cnt - 32'h00000001;
		if (read_done)
			c_next.ready_n = 1'b1;
		case (c_reg.state)
			acm_pkg::ST_CONT, acm_pkg::ST_SINGLE:
			begin
				if (c_reg.cnt != 32'(SETTLE_CYCLES - 1))
					c_next.cnt = c_reg.cnt + 32'h00000001;
				else
				begin
					c_next.cnt = 32'h00000000;
					c_next.sample = raw_sample;
					c_next.sample_ch = c_reg.channel;
					c_next.pending = 1'b1;
					// Ready rises for a cycle so no read starts on a word about to change
					c_next.ready_n = 1'b1;
					c_next.flush = c_reg.cont_active && (!c_reg.ready_n || c_reg.rd_sync[1]);
					nxt = next_chan(channel_enable, {1'b0, c_reg.channel} + 3'h1);
					if (!nxt[2])
					begin
						if (c_reg.state == acm_pkg::ST_SINGLE)
							c_next.state = acm_pkg::ST_STANDBY;
						nxt = next_chan(channel_enable, 3'h0);
					end
					c_next.channel = nxt[1:0];
				end
			end
			acm_pkg::ST_CAL:
			begin
				if (c_reg.cnt != 32'(SETTLE_CYCLES - 1))
					c_next.cnt = c_reg.cnt + 32'h00000001;
				else if (c_reg.cal_code != acm_pkg::MODE_SYS_FULL_CAL)
				begin
					c_next.offset = raw_sample + acm_pkg::MID_SCALE;
					c_next.ready_n = 1'b0;
					c_next.state = acm_pkg::ST_STANDBY;
				end
				else if (cal_diff <= 26'sh0)
				begin
					c_next.gain = acm_pkg::CODE_MAX;
					c_next.ready_n = 1'b0;
					c_next.state = acm_pkg::ST_STANDBY;
				end
				else
				begin
					// Gain solved by a bit-serial divide so full scale lands on the top code in bipolar coding, one code below it in unipolar
					c_next.div_den = cal_diff[24:0];
					c_next.div_num = acm_pkg::DIV_NUMERATOR;
					c_next.div_rem = 26'h0000000;
					c_next.div_quo = 45'h000000000000;
					c_next.div_step = 6'h00;
					c_next.state = acm_pkg::ST_DIV;
				end
			end
			acm_pkg::ST_DIV:
			begin
				c_next.div_rem = quo_n[0] ? rem_sh - {1'b0, c_reg.div_den} : rem_sh;
				c_next.div_quo = quo_n;
				c_next.div_num = {c_reg.div_num[43:0], 1'b0};
				c_next.div_step = c_reg.div_step + 6'h01;
				if (c_reg.div_step == acm_pkg::DIV_LAST_STEP)
				begin
					c_next.gain = (|quo_n[44:24]) ? acm_pkg::CODE_MAX : quo_n[23:0];
					c_next.ready_n = 1'b0;
					c_next.state = acm_pkg::ST_STANDBY;
				end
			end
			default:
			begin
			end
		endcase
		// New result wins over a read-done clear in the same cycle
		if (c_reg.pending && (c_reg.cont_active || !c_reg.rd_sync[1]))
		begin
			c_next.result = scale(c_reg.sample, c_reg.offset, c_reg.gain, bipolar_mode);
			c_next.res_ch = c_reg.sample_ch;
			c_next.ready_n = 1'b0;
		end
		if (mode_write && c_reg.state != acm_pkg::ST_POWERDOWN)
		begin
			nxt = next_chan(channel_enable, 3'h0);
			if (code == acm_pkg::MODE_CONT || code == acm_pkg::MODE_SINGLE)
			begin
				c_next.cnt = 32'h00000000;
				c_next.channel = nxt[1:0];
				c_next.state = (code == acm_pkg::MODE_CONT) ? acm_pkg::ST_CONT : acm_pkg::ST_SINGLE;
				if (code == acm_pkg::MODE_SINGLE)
					c_next.ready_n = 1'b1;
				if (code == acm_pkg::MODE_SINGLE && !nxt[2])
					c_next.state = acm_pkg::ST_STANDBY;
			end
			else if (code == acm_pkg::MODE_STANDBY)
				c_next.state = acm_pkg::ST_STANDBY;
			else if (code == acm_pkg::MODE_POWERDOWN && c_reg.state == acm_pkg::ST_STANDBY)
			begin
				c_next.state = acm_pkg::ST_POWERDOWN;
				c_next.offset = acm_pkg::OFFSET_RESET;
				c_next.gain = acm_pkg::GAIN_RESET;
				c_next.result = 24'h000000;
			end
			else if (code == acm_pkg::MODE_INT_ZERO_CAL || code == acm_pkg::MODE_SYS_ZERO_CAL ||
				code == acm_pkg::MODE_SYS_FULL_CAL)
			begin
				c_next.state = acm_pkg::ST_CAL;
				c_next.cal_code = code;
				c_next.cnt = 32'h00000000;
				c_next.channel = nxt[1:0];
				c_next.ready_n = 1'b1;
			end
		end
		if (c_reg.state != acm_pkg::ST_CAL && c_reg.state != acm_pkg::ST_DIV &&
			c_reg.state != acm_pkg::ST_POWERDOWN)
		begin
			if (offset_write)
				c_next.offset = coef_wdata;
			if (gain_write)
				c_next.gain = coef_wdata;
		end
		// Armed by a rising request; dropped by exit, by the request going low or leaving continuous mode
		c_next.cont_active = (c_next.state == acm_pkg::ST_CONT) && continuous_read_flag &&
			(c_reg.cont_active ? !exit_evt : !c_reg.flag_d);
		if (swr_evt)
		begin
			c_next.state = acm_pkg::ST_CONT;
			c_next.cnt = 32'h00000000;
			nxt = next_chan(channel_enable, 3'h0);
			c_next.channel = nxt[1:0];
			c_next.offset = acm_pkg::OFFSET_RESET;
			c_next.gain = acm_pkg::GAIN_RESET;
			c_next.ready_n = 1'b1;
			c_next.pending = 1'b0;
			c_next.cont_active = 1'b0;
			c_next.settle_cnt = 32'(RESET_WAIT_CYCLES);
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			c_reg <= acm_pkg::CORE_RESET;
		else
			c_reg <= c_next;
	end

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[acm_pkg::STATUS_READY_BIT] = c_reg.ready_n;
		status_byte[acm_pkg::STATUS_CH_MSB:0] = c_reg.res_ch;
	end

	assign conv_channel = c_reg.channel;
	assign data_word = c_reg.result;
	assign offset_value = c_reg.offset;
	assign gain_value = c_reg.gain;
	assign continuous_read_flag_active = c_reg.cont_active;
	assign calibrating = (c_reg.state == acm_pkg::ST_CAL) || (c_reg.state == acm_pkg::ST_DIV);
	assign powered_down = c_reg.state == acm_pkg::ST_POWERDOWN;
	assign gpio_tristate = powered_down;
	assign reset_settling = c_reg.settle_cnt != 32'h00000000;
	// Standby keeps only what software asked for
	assign ref_power_on = !powered_down && (c_reg.state != acm_pkg::ST_STANDBY || ref_enable);
	assign osc_power_on = !powered_down &&
		(c_reg.state != acm_pkg::ST_STANDBY || clock_source_select != 2'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Serial link domain

	// Word is quasi-static outside continuous read: the core holds result and channel while a read is in progress
	assign word = '{result: c_reg.result, status: status_byte, with_status: c_reg.stat_app};
	assign word_len = word.with_status ? acm_pkg::WORD_STAT_BITS : acm_pkg::WORD_BITS;
	assign cont = p_reg.cont_sync[1];
	// Frame state ends with the frame, or is flushed by the core ahead of a new result
	assign frame_rst = rst || cs_n || c_reg.flush;
	assign cmd_full = {f_reg.cmd[6:0], din};

	always_comb
	begin
		p_next = p_reg;
		f_next = f_reg;
		p_next.cont_sync = {p_reg.cont_sync[0], c_reg.cont_active};
		if (f_reg.bit_cnt != acm_pkg::BIT_CNT_MAX)
			f_next.bit_cnt = f_reg.bit_cnt + 6'h01;
		if (f_reg.bit_cnt < acm_pkg::CMD_BITS)
			f_next.cmd = cmd_full;
		// Ones count lives outside the frame state, so a flush ahead of a new result cannot restart it
		if (cs_n || !din)
			p_next.ones_cnt = 7'h00;
		else if (p_reg.ones_cnt != acm_pkg::RESET_ONES)
			p_next.ones_cnt = p_reg.ones_cnt + 7'h01;
		if (!cs_n && din && p_reg.ones_cnt == acm_pkg::RESET_ONES - 7'h01)
			p_next.swr_tgl = ~p_reg.swr_tgl;
		if (cont)
		begin
			if (f_reg.bit_cnt == acm_pkg::CMD_BITS - 6'h01 && cmd_full == acm_pkg::CMD_READ_DATA)
				p_next.exit_tgl = ~p_reg.exit_tgl;
			if (f_reg.bit_cnt == word_len)
				p_next.done_tgl = ~p_reg.done_tgl;
			f_next.reading = (f_next.bit_cnt != 6'h00) && (f_next.bit_cnt <= word_len);
		end
		else
		begin
			case (f_reg.phase)
				acm_pkg::PH_CMD:
				begin
					if (f_reg.bit_cnt == acm_pkg::CMD_BITS - 6'h01)
						f_next.phase = (cmd_full == acm_pkg::CMD_READ_DATA) ? acm_pkg::PH_DATA : acm_pkg::PH_SKIP;
				end
				acm_pkg::PH_DATA:
				begin
					if (f_reg.bit_cnt == acm_pkg::CMD_BITS + word_len - 6'h01)
					begin
						p_next.done_tgl = ~p_reg.done_tgl;
						f_next.phase = acm_pkg::PH_END;
					end
				end
				default:
				begin
				end
			endcase
			f_next.reading = f_next.phase == acm_pkg::PH_DATA;
		end
	end

	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
			p_reg <= acm_pkg::LINK_RESET;
		else
			p_reg <= p_next;
	end

	always_ff @(posedge sclk or posedge frame_rst)
	begin
		if (frame_rst)
			f_reg <= acm_pkg::FRAME_RESET;
		else
			f_reg <= f_next;
	end

	// Pin shows the word bit while a read is under way, the ready level otherwise
	assign idx = cont ? f_reg.bit_cnt - 6'h01 : f_reg.bit_cnt - acm_pkg::CMD_BITS;
	assign show = cont ? (f_reg.bit_cnt != 6'h00 && f_reg.bit_cnt <= word_len) : f_reg.phase == acm_pkg::PH_DATA;
	assign out_bits = {word.result, word.status};
	assign dout = show ? out_bits[~idx[4:0]] : c_reg.ready_n;
	assign dout_oe = !cs_n;

endmodule

// ### test/acm_props.sv
// Port-level checker of the converter mode control block
`timescale 1ns/1ps
module acm_props #(
	parameter int SETTLE_CYCLES = 1000
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Reset
	input wire logic [7:0] mode_control, // Mode byte
	input wire logic mode_write, // Mode strobe
	input wire logic offset_write, // Offset strobe
	input wire logic gain_write, // Gain strobe
	input wire logic [23:0] data_word, // Data register
	input wire logic [7:0] status_byte, // Status
	input wire logic [23:0] offset_value, // Offset
	input wire logic [23:0] gain_value, // Gain
	input wire logic calibrating, // Calibration
	input wire logic powered_down, // Power-down
	input wire logic gpio_tristate, // Outputs released
	input wire logic reset_settling // Serial reset recovery
);
	localparam int FIRST_MAX = SETTLE_CYCLES + 5;
	localparam int CAL_MIN = SETTLE_CYCLES - 10;
	localparam int CAL_SPAN = 70;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	first_result_a: assert property ($fell(rst) |-> ##[1:FIRST_MAX] !status_byte[7])
		else $error("no conversion result after reset");
	reset_coef_a: assert property ($fell(rst) |-> offset_value == 24'h800000 && gain_value == 24'h555555)
		else $error("coefficients not at reset values");
	data_ready_a: assert property ($changed(data_word) && !reset_settling && !powered_down |-> !status_byte[7])
		else $error("data register moved without ready low");
	cal_start_a: assert property (mode_write && !powered_down && !calibrating &&
		mode_control[6:4] inside {3'h4, 3'h6, 3'h7} |=> calibrating && status_byte[7])
		else $error("calibration did not start with ready high");
	cal_end_a: assert property ($fell(calibrating) |-> !status_byte[7])
		else $error("ready not low after calibration");
	cal_time_a: assert property ($rose(calibrating) |-> ##CAL_MIN calibrating ##[1:CAL_SPAN] !calibrating)
		else $error("calibration length wrong");
	coef_lock_a: assert property (calibrating && (offset_write || gain_write) |=>
		!calibrating || $stable({offset_value, gain_value}))
		else $error("coefficient written during calibration");
	down_float_a: assert property (powered_down |-> gpio_tristate)
		else $error("outputs driven in power-down");
	down_entry_a: assert property ($rose(powered_down) |-> $past(mode_write) && $past(mode_control[6:4]) == 3'h3)
		else $error("power-down without its mode code");
	serial_reset_a: assert property ($rose(reset_settling) |-> ##[0:2]
		offset_value == 24'h800000 && gain_value == 24'h555555 && !powered_down)
		else $error("serial reset left state behind");
endmodule
bind acm_mode_control acm_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) acm_props_i (.core_clk(core_clk), .rst(rst),
	.mode_control(mode_control), .mode_write(mode_write), .offset_write(offset_write), .gain_write(gain_write),
	.data_word(data_word), .status_byte(status_byte), .offset_value(offset_value), .gain_value(gain_value),
	.calibrating(calibrating), .powered_down(powered_down), .gpio_tristate(gpio_tristate),
	.reset_settling(reset_settling));

// ### test/acm_host.sv
// Host serial master model of the converter link
`timescale 1ns/1ps
module acm_host (
	output logic sclk, // Serial clock, rests high; xfer with sel low clocks it with chip select high
	output logic cs_n, // Chip select
	output logic din, // Data to device
	input wire logic dout, // Data from device
	output logic [31:0] word, // Last word taken
	output logic done // Pulse after a frame
);
	initial
	begin
		{sclk, cs_n, din, done} = 4'hC;
		word = '0;
	end
	// Bits change on the falling edge, the device is sampled on the rising edge
	task automatic xfer(input int pre, input int n, input logic [7:0] cmd, input logic ones, input logic sel);
		int i;
		cs_n = !sel;
		word = '0;
		for (i = 0; i < pre + n; i++)
		begin
			#32 sclk = 1'b0;
			din = ones || (pre == 8 && i < 8 && cmd[7 - i]);
			#32 sclk = 1'b1;
			if (i >= pre)
				word = {word[30:0], dout};
		end
		#32 din = 1'b0;
		cs_n = 1'b1;
		done = 1'b1;
		#10 done = 1'b0;
	endtask
endmodule

// ### test/adc_operating_mode_control_tb.sv
// Self-checking bench of the converter mode control block
`timescale 1ns/1ps
module adc_operating_mode_control_tb;
	logic core_clk, rst, mode_write, data_stat_flag, continuous_read_flag, bipolar_mode, ref_enable, offset_write;
	logic gain_write, watch, prev_rdy, continuous_read_flag_active, calibrating, powered_down, ref_power_on, osc_power_on;
	logic gpio_tristate, reset_settling, dout, dout_oe, sclk, cs_n, din, hdone, dout_pin;
	logic [7:0] mode_control, status_byte;
	logic [3:0] channel_enable;
	logic [1:0] clock_source_select, conv_channel;
	logic [23:0] raw_sample, coef_wdata, data_word, offset_value, gain_value, v;
	logic [31:0] hword;
	logic [25:0] conv_q[$];
	logic [31:0] read_q[$];
	int errors, n_compared, seed, k;
	assign dout_pin = dout_oe ? dout : 1'bz;
	acm_mode_control #(.SETTLE_CYCLES(300), .RESET_WAIT_CYCLES(30)) acm_mode_control_i (.core_clk(core_clk),
		.rst(rst), .mode_control(mode_control), .mode_write(mode_write), .channel_enable(channel_enable),
		.data_stat_flag(data_stat_flag), .continuous_read_flag(continuous_read_flag), .bipolar_mode(bipolar_mode),
		.ref_enable(ref_enable), .clock_source_select(clock_source_select), .raw_sample(raw_sample),
		.offset_write(offset_write), .gain_write(gain_write), .coef_wdata(coef_wdata), .conv_channel(conv_channel),
		.data_word(data_word), .status_byte(status_byte), .offset_value(offset_value), .gain_value(gain_value),
		.continuous_read_flag_active(continuous_read_flag_active), .calibrating(calibrating), .powered_down(powered_down),
		.ref_power_on(ref_power_on), .osc_power_on(osc_power_on), .gpio_tristate(gpio_tristate),
		.reset_settling(reset_settling), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));
	acm_host acm_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_pin), .word(hword), .done(hdone));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bound(input logic ok);
		if (!ok)
		begin
			errors++;
			$display("Error %0t: wait limit reached", $time);
			print_verdict();
		end
	endtask
	task automatic note(input logic [1:0] ch);
		conv_q.push_back({ch, v});
	endtask
	task automatic drain();
		int i;
		for (i = 0; i < 3000 && conv_q.size() > 0; i++)
			@(negedge core_clk);
		bound(conv_q.size() == 0);
	endtask
	task automatic mw(input logic [2:0] code);
		mode_control = {1'b0, code, 4'h0};
		mode_write = 1'b1;
		@(negedge core_clk);
		mode_write = 1'b0;
		@(negedge core_clk);
	endtask
	// Unity gain keeps the expected scaled value exact for any random input
	task automatic start(input logic bip);
		rst = 1'b1;
		bipolar_mode = bip;
		raw_sample = 24'($random(seed)) & 24'h3FFFFF;
		v = bip ? raw_sample + 24'h800000 : {raw_sample[22:0], 1'b0};
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		coef_wdata = 24'h400000;
		gain_write = 1'b1;
		@(negedge core_clk);
		gain_write = 1'b0;
	endtask
	task automatic cal(input logic [2:0] code, input logic [23:0] raw, input logic [23:0] ofs, input logic [23:0] gn);
		int i;
		raw_sample = raw;
		mw(code);
		{offset_write, gain_write} = 2'h3;
		coef_wdata = 24'h123456;
		@(negedge core_clk);
		{offset_write, gain_write} = 2'h0;
		for (i = 0; i < 1000 && calibrating !== 1'b0; i++)
			@(negedge core_clk);
		bound(calibrating === 1'b0);
		cmp_val(32'(conv_channel), 32'h1);
		cmp_val(32'(offset_value), 32'(ofs));
		cmp_val(32'(gain_value), 32'(gn));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge core_clk)
	begin
		if (!rst && watch && prev_rdy === 1'b1 && status_byte[7] === 1'b0)
		begin
			if (conv_q.size() == 0)
				conv_q.push_back(26'h3FFFFFF);
			cmp_val(32'({status_byte[1:0], data_word}), 32'(conv_q.pop_front()));
		end
		prev_rdy = status_byte[7];
	end
	always @(posedge hdone)
		if (read_q.size() > 0)
			cmp_val(hword & 32'hFFFFFF7F, read_q.pop_front());
	initial
	begin
		seed = 32'h070B5A12;
		{mode_write, offset_write, gain_write, watch, continuous_read_flag, ref_enable, data_stat_flag} = '0;
		{rst, prev_rdy, mode_control, clock_source_select, coef_wdata} = '1;
		channel_enable = 4'hA;
		errors = 0;
		n_compared = 0;
		start(1'b1);
		watch = 1'b1;
		note(2'h0);
		note(2'h1);
		note(2'h3);
		drain();
		data_stat_flag = 1'b1;
		note(2'h1);
		drain();
		read_q.push_back({v, 8'h01});
		note(2'h3);
		acm_host_i.xfer(8, 32, acm_pkg::CMD_READ_DATA, 1'b0, 1'b1);
		repeat (2) @(negedge core_clk);
		cmp_val(32'(status_byte[7]), 32'h1);
		continuous_read_flag = 1'b1;
		acm_host_i.xfer(0, 4, 8'h00, 1'b0, 1'b0);
		drain();
		cmp_val(32'(continuous_read_flag_active), 32'h1);
		note(2'h1);
		drain();
		read_q.push_back({v, 8'h01});
		acm_host_i.xfer(1, 32, 8'h00, 1'b0, 1'b1);
		note(2'h3);
		drain();
		acm_host_i.xfer(8, 0, acm_pkg::CMD_READ_DATA, 1'b0, 1'b1);
		repeat (5) @(negedge core_clk);
		cmp_val(32'(continuous_read_flag_active), 32'h0);
		continuous_read_flag = 1'b0;
		@(negedge core_clk);
		continuous_read_flag = 1'b1;
		acm_host_i.xfer(0, 4, 8'h00, 1'b0, 1'b0);
		cmp_val(32'(continuous_read_flag_active), 32'h1);
		watch = 1'b0;
		acm_host_i.xfer(0, 64, 8'h00, 1'b1, 1'b1);
		repeat (5) @(negedge core_clk);
		cmp_val(32'({continuous_read_flag_active, reset_settling}), 32'h1);
		continuous_read_flag = 1'b0;
		data_stat_flag = 1'b0;
		start(1'b0);
		watch = 1'b1;
		note(2'h0);
		drain();
		mw(acm_pkg::MODE_POWERDOWN);
		cmp_val(32'(powered_down), 32'h0);
		mw(acm_pkg::MODE_CONT);
		mw(acm_pkg::MODE_SINGLE);
		note(2'h1);
		note(2'h3);
		drain();
		repeat (700) @(negedge core_clk);
		for (k = 0; k < 4; k++)
		begin
			{ref_enable, clock_source_select} = 3'(k * 3);
			@(negedge core_clk);
			cmp_val(32'({ref_power_on, osc_power_on}), 32'({ref_enable, clock_source_select != 2'h0}));
		end
		watch = 1'b0;
		v = 24'($random(seed)) & 24'h1FFFFF;
		cal(acm_pkg::MODE_INT_ZERO_CAL, v, v + 24'h800000, 24'h400000);
		cal(acm_pkg::MODE_SYS_ZERO_CAL, v, v + 24'h800000, 24'h400000);
		cal(acm_pkg::MODE_SYS_FULL_CAL, v + 24'h400000, v + 24'h800000, acm_pkg::FULL_SCALE);
		mw(acm_pkg::MODE_STANDBY);
		mw(acm_pkg::MODE_POWERDOWN);
		cmp_val(32'({powered_down, gpio_tristate}), 32'h3);
		acm_host_i.xfer(0, 64, 8'h00, 1'b1, 1'b1);
		repeat (5) @(negedge core_clk);
		cmp_val(32'({powered_down, reset_settling}), 32'h1);
		cmp_val(32'(offset_value), 32'(acm_pkg::OFFSET_RESET));
		print_verdict();
	end
endmodule
